/* mul_div_pkg.sv */
// Shared types and constants of the multiply/divide unit
package mul_div_pkg;

   localparam int WORD_W = 32;
   localparam int HALF_W = 16;
   localparam int PART_W = 50;
   localparam int CNT_W = 6;

   // Multiply repeat and latency figures (cycles)
   localparam int MUL_PAIR_LAT_NARROW = 1;
   localparam int MUL_PAIR_LAT_WIDE = 2;
   localparam int MUL_GPR_LAT_NARROW = 2;
   localparam int MUL_GPR_LAT_WIDE = 3;
   localparam int MUL_REPEAT_NARROW = 1;
   localparam int MUL_REPEAT_WIDE = 2;

   // Divide: latency per dividend size; repeat is one less
   localparam logic [5:0] DIV_LAT_8 = 6'h0C;
   localparam logic [5:0] DIV_LAT_16 = 6'h13;
   localparam logic [5:0] DIV_LAT_24 = 6'h1A;
   localparam logic [5:0] DIV_LAT_32 = 6'h21;
   // Iterations skipped by the early-in check
   localparam logic [5:0] DIV_SKIP_8 = 6'h17;
   localparam logic [5:0] DIV_SKIP_16 = 6'h0F;
   localparam logic [5:0] DIV_SKIP_24 = 6'h07;
   localparam logic [5:0] DIV_SKIP_32 = 6'h00;
   localparam logic [5:0] DIV_FULL_ITER = 6'h20;

   typedef enum logic [4:0] {
      OP_MUL_PAIR = 5'h01,
      OP_MADD_PAIR = 5'h02,
      OP_MSUB_PAIR = 5'h04,
      OP_MUL_GPR = 5'h08,
      OP_DIVIDE = 5'h10
   } op_t;

   typedef enum logic [2:0] {
      MUL_IDLE = 3'h1,
      MUL_PASS1 = 3'h2,
      MUL_PASS2 = 3'h4
   } mul_state_t;

   typedef enum logic [1:0] {
      DIV_IDLE = 2'h1,
      DIV_RUN = 2'h2
   } div_state_t;

   typedef struct packed {
      logic valid;
      op_t op;
      logic is_signed;
      logic [WORD_W-1:0] first_source_operand;
      logic [WORD_W-1:0] second_source_operand;
   } issue_t;

   typedef struct packed {
      logic [WORD_W-1:0] result_high_word;
      logic [WORD_W-1:0] result_low_word;
   } result_pair_t;

endpackage : mul_div_pkg

/* mul_div_unit.sv */
// Integer multiply/divide unit beside the integer pipeline
`timescale 1ns/1ps

// Behaviour
// - The unit runs its own pipeline that keeps advancing whatever the integer pipeline does.
// - The multiplier is a booth-recoded array of a full-width first operand by a half-width second operand per pass.
// - The pass count depends only on the second source operand and its signedness.
// - A second operand that fits in 16 bits takes one pass, a full 32-bit one takes two.
// - A narrow multiply can be taken every cycle, a wide one only every second cycle.
// - Any unit instruction directly after a wide multiply is held off until the multiplier is free.
// - The operand width is found by the unit itself with no hint from outside.
// - Division iterates one quotient bit per clock.
// - The divider skips 23, 15 or 7 iterations when the dividend fits in 8, 16 or 24 bits.
// - While a divide runs, any further unit instruction is stalled until its repeat point, one cycle before the divide result is written.
// - Multiplies to the result pair take 1 cycle latency and repeat narrow, 2 and 2 wide.
// - A multiply to a general register takes 2 latency repeat 1 narrow, 3 latency repeat 2 wide.
// - Divides take 12, 19, 26 or 33 cycles for 8, 16, 24 or 32-bit dividends, repeat one less.
// - Results and accumulations live in a 32-bit high word and a 32-bit low word.
module mul_div_unit
(
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_nrst,
   // Issue from the integer pipeline
   input wire mul_div_pkg::issue_t i_issue,
   // Stall back to the integer pipeline
   output logic o_busy,
   // Result pair and its update pulse
   output mul_div_pkg::result_pair_t o_pair,
   output logic o_pair_done,
   // General register result
   output logic o_gpr_valid,
   output logic [31:0] o_gpr_result
);

   // Radix-4 booth product of signed 33 by signed 17 bits
   function automatic logic [49:0] booth_mul(input logic [32:0] a,
                                              input logic [16:0] b);
      logic [49:0] acc;
      logic [49:0] ae;
      logic [18:0] bx;
      logic [2:0] g;
      acc = '0;
      ae = {{17{a[32]}}, a};
      bx = {b[16], b, 1'b0};
      for (int i = 0; i < 9; i++)
      begin
         g = bx[2*i +: 3];
         case (g)
            3'h1, 3'h2: acc = acc + (ae << (2*i));
            3'h3: acc = acc + (ae << (2*i+1));
            3'h4: acc = acc - (ae << (2*i+1));
            3'h5, 3'h6: acc = acc - (ae << (2*i));
            default: acc = acc;
         endcase
      end
      return acc;
   endfunction : booth_mul

   function automatic logic [63:0] sext_part(input logic [49:0] p);
      return {{14{p[49]}}, p};
   endfunction : sext_part

   // Operand fits in the low n bits, given signedness
   function automatic logic fits(input logic [31:0] v, input logic sgn,
                                 input int n);
      logic ok;
      ok = 1'b1;
      for (int i = 0; i < 32; i++)
      begin
         if (i >= n - 1 && sgn && v[i] != v[31])
            ok = 1'b0;
         if (i >= n && !sgn && v[i])
            ok = 1'b0;
      end
      return ok;
   endfunction : fits

   logic take;
   logic take_mul;
   logic take_wide;
   logic take_div;

   // Issue accepted only when not busy; no pipeline stall input exists
   always_comb
   begin
      take = i_issue.valid && !o_busy;
      take_div = take && i_issue.op == mul_div_pkg::OP_DIVIDE;
      take_mul = take && !take_div;
      take_wide = take_mul && !fits(i_issue.second_source_operand,
                                    i_issue.is_signed, 16);
   end

   // Multiplier stage
   mul_div_pkg::mul_state_t mstate;
   mul_div_pkg::mul_state_t next_mstate;
   mul_div_pkg::op_t mop;
   mul_div_pkg::op_t next_mop;
   logic msgn;
   logic next_msgn;
   logic mwide;
   logic next_mwide;
   logic [31:0] ma;
   logic [31:0] next_ma;
   logic [31:0] mb;
   logic [31:0] next_mb;
   logic [63:0] mlow;
   logic [63:0] next_mlow;
   logic mul_finish;
   logic [63:0] mul_product;
   logic [32:0] a_ext;
   logic [16:0] b_chunk;

   always_comb
   begin
      next_mstate = mstate;
      next_mop = mop;
      next_msgn = msgn;
      next_mwide = mwide;
      next_ma = ma;
      next_mb = mb;
      next_mlow = mlow;
      mul_finish = 1'b0;
      mul_product = '0;
      a_ext = {msgn & ma[31], ma};
      b_chunk = {msgn & mb[15], mb[15:0]};
      case (mstate)
         mul_div_pkg::MUL_IDLE: ;
         mul_div_pkg::MUL_PASS1:
         begin
            if (mwide)
            begin
               b_chunk = {1'b0, mb[15:0]};
               next_mlow = sext_part(booth_mul(a_ext, b_chunk));
               next_mstate = mul_div_pkg::MUL_PASS2;
            end
            else
            begin
               mul_product = sext_part(booth_mul(a_ext, b_chunk));
               mul_finish = 1'b1;
               next_mstate = mul_div_pkg::MUL_IDLE;
            end
         end
         mul_div_pkg::MUL_PASS2:
         begin
            b_chunk = {msgn & mb[31], mb[31:16]};
            mul_product = mlow
               + (sext_part(booth_mul(a_ext, b_chunk)) << 16);
            mul_finish = 1'b1;
            next_mstate = mul_div_pkg::MUL_IDLE;
         end
         default: next_mstate = mul_div_pkg::MUL_IDLE;
      endcase
      if (take_mul)
      begin
         next_mstate = mul_div_pkg::MUL_PASS1;
         next_mop = i_issue.op;
         next_msgn = i_issue.is_signed;
         next_mwide = take_wide;
         next_ma = i_issue.first_source_operand;
         next_mb = i_issue.second_source_operand;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         mstate <= mul_div_pkg::MUL_IDLE;
         mop <= mul_div_pkg::OP_MUL_PAIR;
         msgn <= 1'b0;
         mwide <= 1'b0;
         ma <= '0;
         mb <= '0;
         mlow <= '0;
      end
      else
      begin
         mstate <= next_mstate;
         mop <= next_mop;
         msgn <= next_msgn;
         mwide <= next_mwide;
         ma <= next_ma;
         mb <= next_mb;
         mlow <= next_mlow;
      end
   end

   // Divider stage
   mul_div_pkg::div_state_t dstate;
   mul_div_pkg::div_state_t next_dstate;
   logic [5:0] dcnt;
   logic [5:0] next_dcnt;
   logic [5:0] diter;
   logic [5:0] next_diter;
   logic [31:0] drem;
   logic [31:0] next_drem;
   logic [31:0] dquo;
   logic [31:0] next_dquo;
   logic [31:0] ddvs;
   logic [31:0] next_ddvs;
   logic dneg_q;
   logic next_dneg_q;
   logic dneg_r;
   logic next_dneg_r;
   logic div_finish;
   logic [31:0] div_q;
   logic [31:0] div_r;
   logic [32:0] trial;
   logic [31:0] mag;
   logic [5:0] skip;
   logic [5:0] lat;
   logic dpend;
   logic next_dpend;
   logic [63:0] dres;
   logic [63:0] next_dres;

   always_comb
   begin
      next_dstate = dstate;
      next_dcnt = dcnt;
      next_diter = diter;
      next_drem = drem;
      next_dquo = dquo;
      next_ddvs = ddvs;
      next_dneg_q = dneg_q;
      next_dneg_r = dneg_r;
      next_dpend = 1'b0;
      next_dres = dres;
      div_finish = dpend;
      trial = {drem, dquo[31]} - {1'b0, ddvs};
      case (dstate)
         mul_div_pkg::DIV_IDLE: ;
         mul_div_pkg::DIV_RUN:
         begin
            next_dcnt = dcnt - 6'h01;
            if (diter != 6'h00)
            begin
               next_diter = diter - 6'h01;
               next_drem = trial[32] ? {drem[30:0], dquo[31]} : trial[31:0];
               next_dquo = {dquo[30:0], !trial[32]};
            end
         end
         default: next_dstate = mul_div_pkg::DIV_IDLE;
      endcase
      // Sign-fixed result after this edge's iteration
      div_q = dneg_q ? 32'h0 - next_dquo : next_dquo;
      div_r = dneg_r ? 32'h0 - next_drem : next_drem;
      // Held one edge so a divide taken at the repeat point keeps it;
      // a zero divisor just runs out the count
      if (dstate == mul_div_pkg::DIV_RUN && dcnt == 6'h02)
      begin
         next_dpend = 1'b1;
         next_dres = {div_r, div_q};
         next_dstate = mul_div_pkg::DIV_IDLE;
      end
      mag = (i_issue.is_signed && i_issue.first_source_operand[31])
         ? 32'h0 - i_issue.first_source_operand
         : i_issue.first_source_operand;
      if (fits(i_issue.first_source_operand, i_issue.is_signed, 8))
      begin
         skip = mul_div_pkg::DIV_SKIP_8;
         lat = mul_div_pkg::DIV_LAT_8;
      end
      else if (fits(i_issue.first_source_operand, i_issue.is_signed, 16))
      begin
         skip = mul_div_pkg::DIV_SKIP_16;
         lat = mul_div_pkg::DIV_LAT_16;
      end
      else if (fits(i_issue.first_source_operand, i_issue.is_signed, 24))
      begin
         skip = mul_div_pkg::DIV_SKIP_24;
         lat = mul_div_pkg::DIV_LAT_24;
      end
      else
      begin
         skip = mul_div_pkg::DIV_SKIP_32;
         lat = mul_div_pkg::DIV_LAT_32;
      end
      if (take_div)
      begin
         next_dstate = mul_div_pkg::DIV_RUN;
         next_dcnt = lat;
         next_diter = mul_div_pkg::DIV_FULL_ITER - skip;
         next_drem = '0;
         next_dquo = mag << skip;
         next_ddvs = (i_issue.is_signed && i_issue.second_source_operand[31])
            ? 32'h0 - i_issue.second_source_operand
            : i_issue.second_source_operand;
         next_dneg_q = i_issue.is_signed && (i_issue.first_source_operand[31]
            ^ i_issue.second_source_operand[31]);
         next_dneg_r = i_issue.is_signed && i_issue.first_source_operand[31];
      end
   end

   always_ff @(posedge i_core_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         dstate <= mul_div_pkg::DIV_IDLE;
         dcnt <= '0;
         diter <= '0;
         drem <= '0;
         dquo <= '0;
         ddvs <= '0;
         dneg_q <= 1'b0;
         dneg_r <= 1'b0;
         dpend <= 1'b0;
         dres <= '0;
      end
      else
      begin
         dstate <= next_dstate;
         dcnt <= next_dcnt;
         diter <= next_diter;
         drem <= next_drem;
         dquo <= next_dquo;
         ddvs <= next_ddvs;
         dneg_q <= next_dneg_q;
         dneg_r <= next_dneg_r;
         dpend <= next_dpend;
         dres <= next_dres;
      end
   end

   // Result pair, general register result and busy
   mul_div_pkg::result_pair_t next_pair;
   mul_div_pkg::result_pair_t base;
   logic next_pair_done;
   logic next_busy;
   logic gpr_pend;
   logic next_gpr_pend;
   logic [31:0] gpr_hold;
   logic [31:0] next_gpr_hold;
   logic next_gpr_valid;
   logic [31:0] next_gpr_result;

   always_comb
   begin
      next_pair = o_pair;
      next_pair_done = 1'b0;
      next_gpr_pend = 1'b0;
      next_gpr_hold = gpr_hold;
      next_gpr_valid = gpr_pend;
      next_gpr_result = gpr_pend ? gpr_hold : o_gpr_result;
      // Accumulate sees a divide that ends this very edge
      base = div_finish ? dres : o_pair;
      if (div_finish)
      begin
         next_pair = dres;
         next_pair_done = 1'b1;
      end
      if (mul_finish)
      begin
         case (mop)
            mul_div_pkg::OP_MADD_PAIR:
               next_pair = base + mul_product;
            mul_div_pkg::OP_MSUB_PAIR:
               next_pair = base - mul_product;
            mul_div_pkg::OP_MUL_GPR:
               next_pair = base;
            default: next_pair = mul_product;
         endcase
         if (mop == mul_div_pkg::OP_MUL_GPR)
         begin
            next_gpr_pend = 1'b1;
            next_gpr_hold = mul_product[31:0];
         end
         else
            next_pair_done = 1'b1;
      end
      // Wide pass two, or divide up to its repeat point
      next_busy = take_wide || take_div
         || (dstate == mul_div_pkg::DIV_RUN && dcnt > 6'h03);
   end

   // Own pipeline; nothing here waits on the integer pipeline
   always_ff @(posedge i_core_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         o_pair <= '0;
         o_pair_done <= 1'b0;
         o_busy <= 1'b0;
         gpr_pend <= 1'b0;
         gpr_hold <= '0;
         o_gpr_valid <= 1'b0;
         o_gpr_result <= '0;
      end
      else
      begin
         o_pair <= next_pair;
         o_pair_done <= next_pair_done;
         o_busy <= next_busy;
         gpr_pend <= next_gpr_pend;
         gpr_hold <= next_gpr_hold;
         o_gpr_valid <= next_gpr_valid;
         o_gpr_result <= next_gpr_result;
      end
   end

endmodule : mul_div_unit

/* mul_div_unit_chk.sv */
// Port-level assertions of the multiply/divide unit
`timescale 1ns/1ps
module mul_div_unit_chk
(
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_nrst,
   // Issue side
   input wire mul_div_pkg::issue_t i_issue,
   input wire logic o_busy,
   // Results
   input wire mul_div_pkg::result_pair_t o_pair,
   input wire logic o_pair_done,
   input wire logic o_gpr_valid,
   input wire logic [31:0] o_gpr_result
);
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_nrst);
   logic take;
   logic narrow;
   logic div;
   logic gpr;
   logic pairop;
   logic longtake;
   logic [31:0] lowprod;
   logic [31:0] b;
   assign b = i_issue.second_source_operand;
   assign take = i_issue.valid && !o_busy;
   assign narrow = i_issue.is_signed ? (&b[31:15] || ~|b[31:15]) : ~|b[31:16];
   assign div = i_issue.op == mul_div_pkg::OP_DIVIDE;
   assign gpr = i_issue.op == mul_div_pkg::OP_MUL_GPR;
   assign pairop = !div && !gpr;
   assign longtake = take && (div || !narrow);
   assign lowprod = i_issue.first_source_operand * b;
   sequence s_div_hold;
      o_busy [*8];
   endsequence
   sequence s_div_wait;
      !o_pair_done [*7] ##[4:25] o_pair_done;
   endsequence
   property p_pair_narrow;
      take && pairop && narrow |-> ##2 o_pair_done;
   endproperty
   a_pair_narrow: assert property (p_pair_narrow)
      else $error("narrow pair result late");
   property p_pair_wide;
      take && pairop && !narrow |-> ##3 o_pair_done;
   endproperty
   a_pair_wide: assert property (p_pair_wide)
      else $error("wide pair result late");
   property p_wide_busy;
      take && !div && !narrow |=> o_busy ##1 !o_busy;
   endproperty
   a_wide_busy: assert property (p_wide_busy)
      else $error("wide multiply stall wrong");
   property p_narrow_free;
      take && !div && narrow |=> !o_busy;
   endproperty
   a_narrow_free: assert property (p_narrow_free)
      else $error("narrow multiply stalled");
   property p_div_busy;
      take && div |=> s_div_hold;
   endproperty
   a_div_busy: assert property (p_div_busy)
      else $error("divide stall dropped early");
   property p_div_done;
      take && div |=> ##2 s_div_wait;
   endproperty
   a_div_done: assert property (p_div_done)
      else $error("divide end outside window");
   property p_gpr_narrow;
      take && gpr && narrow |-> ##3 o_gpr_valid &&
         o_gpr_result == $past(lowprod, 3);
   endproperty
   a_gpr_narrow: assert property (p_gpr_narrow)
      else $error("narrow register result wrong");
   property p_gpr_wide;
      take && gpr && !narrow |-> ##4 o_gpr_valid;
   endproperty
   a_gpr_wide: assert property (p_gpr_wide)
      else $error("wide register result late");
   property p_busy_cause;
      $rose(o_busy) |-> $past(longtake);
   endproperty
   a_busy_cause: assert property (p_busy_cause)
      else $error("stall without cause");
endmodule : mul_div_unit_chk

/* int_pipe_model.sv */
// Integer pipeline model that issues queued instructions to the unit
`timescale 1ns/1ps
module int_pipe_model
(
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_nrst,
   // Stall from the unit
   input wire logic i_busy,
   // Instructions from the bench
   input wire mul_div_pkg::issue_t i_req,
   input wire logic i_load,
   // Issue to the unit
   output mul_div_pkg::issue_t o_issue
);
   mul_div_pkg::issue_t fifo[$];
   logic gone = 1'b0;
   initial o_issue = '0;
   always @(posedge i_core_clk)
   begin
      if (i_load === 1'b1)
         fifo.push_back(i_req);
      gone <= o_issue.valid && (i_busy === 1'b0);
   end
   // Held until taken, no size hint; idle operands toggle
   always @(negedge i_core_clk)
   begin
      if (!o_issue.valid || gone)
      begin
         if (fifo.size() > 0 && i_nrst)
            o_issue = fifo.pop_front();
         else
         begin
            o_issue.valid = 1'b0;
            o_issue.first_source_operand = ~o_issue.first_source_operand;
            o_issue.second_source_operand = ~o_issue.second_source_operand;
         end
      end
   end
endmodule : int_pipe_model

/* integer_multiply_divide_unit_bench.sv */
// Self-checking bench of the multiply/divide unit
`timescale 1ns/1ps
module integer_multiply_divide_unit_bench;
   logic i_core_clk = 1'b0;
   logic i_nrst = 1'b0;
   logic load = 1'b0;
   mul_div_pkg::issue_t req = '0;
   mul_div_pkg::issue_t iss;
   mul_div_pkg::result_pair_t o_pair;
   logic o_busy;
   logic o_pair_done;
   logic o_gpr_valid;
   logic [31:0] o_gpr_result;
   int error_cnt = 0;
   int checked = 0;
   int cyc = 0;
   int tk[$];
   int dn[$];
   int gv[$];
   logic [63:0] pv[$];
   logic [31:0] rv[$];

   always #50 i_core_clk = ~i_core_clk;

   mul_div_unit uut(.i_core_clk, .i_nrst, .i_issue(iss), .o_busy, .o_pair,
      .o_pair_done, .o_gpr_valid, .o_gpr_result);
   int_pipe_model partner(.i_core_clk, .i_nrst, .i_busy(o_busy),
      .i_req(req), .i_load(load), .o_issue(iss));

   // Edge numbers of takes and result writes
   always @(posedge i_core_clk)
   begin
      if (iss.valid === 1'b1 && o_busy === 1'b0)
         tk.push_back(cyc);
      if (o_pair_done === 1'b1)
      begin
         dn.push_back(cyc - 1);
         pv.push_back(o_pair);
      end
      if (o_gpr_valid === 1'b1)
      begin
         gv.push_back(cyc - 1);
         rv.push_back(o_gpr_result);
      end
      cyc++;
   end

   function automatic logic [63:0] prod(logic s, logic [31:0] a,
      logic [31:0] b);
      logic [63:0] x;
      logic [63:0] y;
      x = s ? {{32{a[31]}}, a} : {32'h0, a};
      y = s ? {{32{b[31]}}, b} : {32'h0, b};
      return x * y;
   endfunction : prod

   task automatic check(logic [63:0] got, logic [63:0] exp);
      checked++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask : check

   task automatic send(mul_div_pkg::op_t op, logic s, logic [31:0] a,
      logic [31:0] b);
      @(negedge i_core_clk);
      req = '{1'b1, op, s, a, b};
      load = 1'b1;
   endtask : send

   task automatic settle(int np, int ng);
      int k;
      @(negedge i_core_clk);
      load = 1'b0;
      for (k = 0; k < 400 && (dn.size() < np || gv.size() < ng); k++)
         @(negedge i_core_clk);
   endtask : settle

   task automatic clr;
      tk.delete();
      dn.delete();
      gv.delete();
      pv.delete();
      rv.delete();
   endtask : clr

   task automatic t_reset;
      check({o_busy, o_pair_done, o_gpr_valid}, 64'h0);
      check(o_pair, 64'h0);
      check(o_gpr_result, 64'h0);
      $display("test reset ended");
   endtask : t_reset

   task automatic t_narrow;
      logic [63:0] e1 = prod(1'b1, 32'h9ABC_DEF1, 32'hFFFF_8000);
      logic [63:0] e2 = prod(1'b1, 32'h7FFF_FFFF, 32'h0000_7FFF);
      logic [63:0] e3 = prod(1'b0, 32'hFFFF_FFFF, 32'h0000_FFFF);
      int i;
      clr();
      send(mul_div_pkg::OP_MUL_PAIR, 1'b1, 32'h9ABC_DEF1, 32'hFFFF_8000);
      send(mul_div_pkg::OP_MADD_PAIR, 1'b1, 32'h7FFF_FFFF, 32'h0000_7FFF);
      send(mul_div_pkg::OP_MSUB_PAIR, 1'b0, 32'hFFFF_FFFF, 32'h0000_FFFF);
      settle(3, 0);
      for (i = 0; i < 3; i++)
      begin
         if (i > 0)
            check(tk[i] - tk[i-1], mul_div_pkg::MUL_REPEAT_NARROW);
         check(dn[i] - tk[i], mul_div_pkg::MUL_PAIR_LAT_NARROW);
      end
      check(pv[0], e1);
      check(pv[1], e1 + e2);
      check(pv[2], e1 + e2 - e3);
      $display("test narrow_pair ended");
   endtask : t_narrow

   task automatic t_wide;
      clr();
      send(mul_div_pkg::OP_MUL_PAIR, 1'b0, 32'h1234_5678, 32'hFFFF_0003);
      send(mul_div_pkg::OP_MUL_PAIR, 1'b1, 32'hF000_000F, 32'h0001_0000);
      settle(2, 0);
      check(tk[1] - tk[0], mul_div_pkg::MUL_REPEAT_WIDE);
      check(dn[0] - tk[0], mul_div_pkg::MUL_PAIR_LAT_WIDE);
      check(dn[1] - tk[1], mul_div_pkg::MUL_PAIR_LAT_WIDE);
      check(pv[0], prod(1'b0, 32'h1234_5678, 32'hFFFF_0003));
      check(pv[1], prod(1'b1, 32'hF000_000F, 32'h0001_0000));
      $display("test wide_pair ended");
   endtask : t_wide

   task automatic t_gpr;
      logic [31:0] a[3] = '{32'h89AB_CDEF, 32'h0000_1001, 32'h1357_9BDF};
      logic [31:0] b[3] = '{32'hFFFF_FFF0, 32'h0002_0000, 32'h0000_0005};
      logic s[3] = '{1'b1, 1'b0, 1'b0};
      int lat[3] = '{2, 3, 2};
      logic [63:0] keep;
      int i;
      clr();
      keep = o_pair;
      for (i = 0; i < 3; i++)
         send(mul_div_pkg::OP_MUL_GPR, s[i], a[i], b[i]);
      settle(0, 3);
      check(tk[1] - tk[0], mul_div_pkg::MUL_REPEAT_NARROW);
      check(tk[2] - tk[1], mul_div_pkg::MUL_REPEAT_WIDE);
      for (i = 0; i < 3; i++)
      begin
         check(gv[i] - tk[i], lat[i]);
         check(rv[i], prod(s[i], a[i], b[i]) & 64'hFFFF_FFFF);
      end
      check(o_pair, keep);
      $display("test register_mul ended");
   endtask : t_gpr

   task automatic t_div;
      logic [31:0] dv[4] = '{32'hFFFF_FF85, 32'h0000_1234, 32'h0012_3456,
         32'h1234_5678};
      int lat[4] = '{mul_div_pkg::DIV_LAT_8, mul_div_pkg::DIV_LAT_16,
         mul_div_pkg::DIV_LAT_24, mul_div_pkg::DIV_LAT_32};
      logic signed [31:0] sa;
      int i;
      for (i = 0; i < 4; i++)
      begin
         clr();
         sa = dv[i];
         send(mul_div_pkg::OP_DIVIDE, 1'b1, dv[i], 32'h0000_0007);
         send(mul_div_pkg::OP_MUL_GPR, 1'b0, 32'h0000_0003, 32'h0000_0005);
         settle(1, 1);
         check(tk[1] - tk[0], lat[i] - 1);
         check(dn[0] - tk[0], lat[i]);
         check(pv[0], {sa % 32'sh7, sa / 32'sh7});
         check(gv[0] - tk[1], mul_div_pkg::MUL_GPR_LAT_NARROW);
      end
      clr();
      send(mul_div_pkg::OP_DIVIDE, 1'b0, 32'h8000_0000, 32'h0000_0000);
      settle(1, 0);
      check(dn[0] - tk[0], mul_div_pkg::DIV_LAT_32);
      check(pv[0], 64'h8000_0000_FFFF_FFFF);
      clr();
      send(mul_div_pkg::OP_DIVIDE, 1'b0, 32'h0000_0064, 32'h0000_0009);
      send(mul_div_pkg::OP_DIVIDE, 1'b0, 32'h0000_0031, 32'h0000_0004);
      settle(2, 0);
      check(tk[1] - tk[0], mul_div_pkg::DIV_LAT_8 - 1);
      check(dn[0] - tk[0], mul_div_pkg::DIV_LAT_8);
      check(pv[0], {32'h0000_0001, 32'h0000_000B});
      check(pv[1], {32'h0000_0001, 32'h0000_000C});
      $display("test divide ended");
   endtask : t_div

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : give_verdict

   initial
   begin
      repeat (4) @(posedge i_core_clk);
      @(negedge i_core_clk);
      i_nrst = 1'b1;
      t_reset();
      t_narrow();
      t_wide();
      t_gpr();
      t_div();
      give_verdict();
   end

   initial
   begin
      #200000;
      error_cnt++;
      give_verdict();
   end
endmodule : integer_multiply_divide_unit_bench

bind mul_div_unit mul_div_unit_chk chk(.i_core_clk, .i_nrst, .i_issue,
   .o_busy, .o_pair, .o_pair_done, .o_gpr_valid, .o_gpr_result);
